// *** inc/tca_map.svh ***
`ifndef TCA_MAP_SVH
`define TCA_MAP_SVH

// Register indices; byte address on the bus is four times the index
`define TCA_IDX_LAPD3_STATUS 12'hb28
`define TCA_IDX_LAPD3_ENABLE 12'hb29
`define TCA_IDX_CI_STATUS 12'hb40
`define TCA_IDX_CI_ENABLE 12'hb41
`define TCA_IDX_CI_DETECT 12'h11c

// Field positions
`define TCA_BIT_AIS_LIVE 5
`define TCA_BIT_RAI_LIVE 4
`define TCA_BIT_AIS_CHG 1
`define TCA_BIT_RAI_CHG 0
`define TCA_BIT_LAPD3 0
`define TCA_BIT_DET_AIS 1
`define TCA_BIT_DET_RAI 0

// Reset value of every register
`define TCA_RST_REG 8'h00

// Clock and the 1 ms enable pulse
`define TCA_CLK_PERIOD_NS 100
`define TCA_MS_NS 1000000
`define TCA_MS_CYCLES (`TCA_MS_NS / `TCA_CLK_PERIOD_NS)

// AIS-CI: signature right to left, recurring every 386 bits
`define TCA_AIS_SIG 16'h7cff
`define TCA_AIS_PERIOD_BITS 9'h182
`define TCA_AIS_SIG_ZEROS 3'h3
`define TCA_AIS_HITS 3'h4

// RAI-CI: 1080 ms period, 990 ms message, 90 ms signature
`define TCA_RAI_MSG 16'h00ff
`define TCA_RAI_SIG 16'h3eff
`define TCA_RAI_PERIOD_MS 12'h438
`define TCA_RAI_MSG_MS 12'h3de
`define TCA_RAI_SIG_MS 12'h05a
`define TCA_RAI_LOSS_MS 12'h870

// Oversize LAPD message limit in bytes (276)
`define TCA_LAPD_MAX_BYTES 9'h114

`endif

// *** inc/tca_pkg.sv ***
package tca_pkg;

	// Register payload
	typedef logic [7:0] tca_reg_t;

	// Bus slave sequencing
	typedef enum logic [0:0] {bus_idle, bus_ack} tca_bus_state_e;

	// RAI-CI pattern tracking
	typedef enum logic [1:0] {rai_hunt, rai_msg, rai_sig} tca_rai_state_e;

endpackage : tca_pkg

// *** inc/tca_det_if.sv ***
`timescale 1ns/1ns
interface tca_det_if;
	logic line_bit;
	logic line_valid;
	logic dl_bit;
	logic dl_valid;
	logic esf_mode;
	logic ms_tick;
	logic ais_det;
	logic rai_det;

	// Pattern detector side
	modport det (input line_bit, line_valid, dl_bit, dl_valid, esf_mode, ms_tick,
		output ais_det, rai_det);

	// Register bank side
	modport ctl (output line_bit, line_valid, dl_bit, dl_valid, esf_mode, ms_tick,
		input ais_det, rai_det);
endinterface : tca_det_if

// *** core/tca_ci_detect.sv ***
`timescale 1ns/1ns
`include "tca_map.svh"
module tca_ci_detect (
	input wire logic i_clock, // Framer clock
	input wire logic i_rst_b, // Synchronous reset, active low
	tca_det_if.det det // Line bits in, detections out
);
	logic [15:0] ais_sr_q;
	logic [8:0] ais_cnt_q;
	logic [2:0] ais_zero_q;
	logic [2:0] ais_hits_q;
	logic ais_det_q;
	logic [15:0] rai_sr_q;
	logic [11:0] rai_ms_q;
	logic rai_armed_q;
	logic rai_det_q;
	tca_pkg::tca_rai_state_e rai_state_q;
	tca_pkg::tca_rai_state_e rai_state_d;

	// AIS-CI: first received bit ends up in bit 0, so match reads right to left
	wire [15:0] ais_sr_next = {det.line_bit, ais_sr_q[15:1]};
	wire ais_sig_hit = ais_sr_next == `TCA_AIS_SIG;
	wire [8:0] ais_cnt_next = (ais_cnt_q == 9'h1ff) ? ais_cnt_q : ais_cnt_q + 9'h001;
	wire ais_zero_inc = ~det.line_bit & (ais_zero_q != 3'h7);
	wire [2:0] ais_zero_next = ais_zero_q + {2'h0, ais_zero_inc};
	// Only the signature zeros are allowed; the rest of the 386 bits must be ones
	wire ais_good = ais_sig_hit && (ais_cnt_next == `TCA_AIS_PERIOD_BITS) &&
		(ais_zero_next == `TCA_AIS_SIG_ZEROS);
	wire ais_late = !ais_sig_hit && (ais_cnt_next > `TCA_AIS_PERIOD_BITS);
	wire [2:0] ais_hits_up = (ais_hits_q == `TCA_AIS_HITS) ? ais_hits_q : ais_hits_q + 3'h1;
	wire [2:0] ais_hits_next = ais_good ? ais_hits_up :
		(ais_sig_hit || ais_late) ? 3'h0 : ais_hits_q;

	// AIS-CI tracker, advanced per line bit
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			ais_sr_q <= 16'h0000;
			ais_cnt_q <= 9'h000;
			ais_zero_q <= 3'h0;
			ais_hits_q <= 3'h0;
			ais_det_q <= 1'b0;
		end
		else if (det.line_valid)
		begin
			ais_sr_q <= ais_sr_next;
			ais_cnt_q <= ais_sig_hit ? 9'h000 : ais_cnt_next;
			ais_zero_q <= ais_sig_hit ? 3'h0 : ais_zero_next;
			ais_hits_q <= ais_hits_next;
			ais_det_q <= (ais_hits_next == `TCA_AIS_HITS) | (ais_det_q & (ais_hits_next != 3'h0));
		end
	end

	// RAI-CI matchers on the ESF data link bits
	wire [15:0] rai_sr_next = {det.dl_bit, rai_sr_q[15:1]};
	wire rai_msg_hit = det.dl_valid && (rai_sr_next == `TCA_RAI_MSG);
	wire rai_sig_hit = det.dl_valid && (rai_sr_next == `TCA_RAI_SIG);
	wire rai_seg_start = rai_sig_hit && (rai_state_q == tca_pkg::rai_msg);
	wire [11:0] rai_ms_next = (det.ms_tick && rai_ms_q != 12'hfff) ? rai_ms_q + 12'h001 : rai_ms_q;
	// Segment starts must recur 990 to 1170 ms apart, after a full message run
	wire rai_period_ok = rai_armed_q && (rai_ms_q >= `TCA_RAI_MSG_MS) &&
		(rai_ms_q <= `TCA_RAI_PERIOD_MS + `TCA_RAI_SIG_MS);
	wire rai_lost = rai_ms_next > `TCA_RAI_LOSS_MS;

	// Message run, then signature run, then message again
	always_comb
	begin
		rai_state_d = rai_state_q;
		case (rai_state_q)
			tca_pkg::rai_hunt: if (rai_msg_hit) rai_state_d = tca_pkg::rai_msg;
			tca_pkg::rai_msg: if (rai_seg_start) rai_state_d = tca_pkg::rai_sig;
			tca_pkg::rai_sig: if (rai_msg_hit) rai_state_d = tca_pkg::rai_msg;
			default: rai_state_d = tca_pkg::rai_hunt;
		endcase
		if (!det.esf_mode) rai_state_d = tca_pkg::rai_hunt;
	end

	// RAI-CI tracker; leaving ESF drops everything
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b || !det.esf_mode)
		begin
			rai_sr_q <= 16'h0000;
			rai_ms_q <= 12'h000;
			rai_armed_q <= 1'b0;
			rai_det_q <= 1'b0;
			rai_state_q <= tca_pkg::rai_hunt;
		end
		else
		begin
			if (det.dl_valid) rai_sr_q <= rai_sr_next;
			rai_state_q <= rai_state_d;
			rai_ms_q <= rai_seg_start ? 12'h000 : rai_ms_next;
			rai_armed_q <= rai_seg_start | (rai_armed_q & ~rai_lost);
			rai_det_q <= rai_seg_start ? rai_period_ok : (rai_det_q & ~rai_lost);
		end
	end

	assign det.ais_det = ais_det_q;
	assign det.rai_det = rai_det_q;
endmodule : tca_ci_detect

// *** core/tca_ci_alarm_status_irq.sv ***
// How it works
// - Oversize LAPD3 message over 276 bytes raises the interrupt when enabled.
// - Enable bit 0 of the LAPD3 enable register gates the oversize interrupt.
// - Status bit 5 shows the live AIS-CI condition.
// - AIS-CI is all ones with a 16-bit signature every 386 bits.
// - AIS-CI live bit only reports while AIS-CI detection is enabled.
// - Status bit 4 shows live RAI-CI, only in ESF framing.
// - RAI-CI repeats every 1.08 s: 0.99 s message, 90 ms signature.
// - RAI message and signature words matched right to left.
// - RAI-CI live bit only reports while RAI-CI detection is enabled.
// - Change flag bit 1 sets on AIS-CI onset and on its clearing.
// - Change flags read as event-since-last-read and clear on that read.
// - Change flag bit 0 sets on RAI-CI onset and on its clearing.
// - Enable bit 1 gates the AIS-CI change interrupt, resets to 0.
// - Enable bit 0 gates the RAI-CI change interrupt, resets to 0.
// - Oversize status bit 0 records the event since last read.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "tca_map.svh"
module tca_ci_alarm_status_irq #(
	parameter int MS_CYCLES = `TCA_MS_CYCLES // Clock cycles per 1 ms tick
) (
	input wire logic i_clock, // Framer clock, 10 MHz
	input wire logic i_rst_b, // Synchronous reset, active low
	input wire logic [13:0] i_avs_address, // Avalon byte address
	input wire logic i_avs_read, // Avalon read request
	input wire logic i_avs_write, // Avalon write request
	input wire logic [31:0] i_avs_writedata, // Avalon write data
	input wire logic [3:0] i_avs_byteenable, // Avalon byte enables
	output logic [31:0] o_avs_readdata, // Avalon read data
	output logic o_avs_waitrequest, // Avalon wait, low to complete
	input wire logic i_rx_bit, // Received T1 line bit
	input wire logic i_rx_bit_valid, // Strobe for i_rx_bit
	input wire logic i_dl_bit, // Received ESF data link bit
	input wire logic i_dl_bit_valid, // Strobe for i_dl_bit
	input wire logic i_esf_mode, // Framer runs ESF framing
	input wire logic i_lapd3_rx_byte, // LAPD3 received one message byte
	input wire logic i_lapd3_rx_eom, // LAPD3 message ended
	output logic o_irq // Level interrupt request, active high
);
	// Bus sequencing
	tca_pkg::tca_bus_state_e bus_state_q;
	tca_pkg::tca_bus_state_e bus_state_d;
	logic wait_q;
	logic [31:0] rdata_q;

	// Registers and flags
	logic lapd3_en_q;
	logic lapd3_flag_q;
	logic lapd3_flag_d;
	logic [1:0] ci_en_q;
	logic [1:0] ci_en_d;
	logic [1:0] det_en_q;
	logic [1:0] det_en_d;
	logic lapd3_en_d;
	logic ais_live_q;
	logic rai_live_q;
	logic ais_flag_q;
	logic rai_flag_q;
	logic ais_flag_d;
	logic rai_flag_d;
	logic irq_q;

	// Oversize counter and the millisecond divider
	logic [8:0] lapd3_cnt_q;
	logic [8:0] lapd3_cnt_d;
	logic [13:0] div_q;
	logic tick_q;

	// Detector link
	tca_det_if det_bus ();

	assign det_bus.line_bit = i_rx_bit;
	assign det_bus.line_valid = i_rx_bit_valid;
	assign det_bus.dl_bit = i_dl_bit;
	assign det_bus.dl_valid = i_dl_bit_valid;
	assign det_bus.esf_mode = i_esf_mode;
	assign det_bus.ms_tick = tick_q;

	tca_ci_detect u_detect (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.det (det_bus.det)
	);

	// Address decode; misaligned addresses hit nothing
	wire [11:0] reg_idx = i_avs_address[13:2];
	wire aligned = i_avs_address[1:0] == 2'h0;
	wire hit_lapd3_st = aligned && (reg_idx == `TCA_IDX_LAPD3_STATUS);
	wire hit_lapd3_en = aligned && (reg_idx == `TCA_IDX_LAPD3_ENABLE);
	wire hit_ci_st = aligned && (reg_idx == `TCA_IDX_CI_STATUS);
	wire hit_ci_en = aligned && (reg_idx == `TCA_IDX_CI_ENABLE);
	wire hit_det = aligned && (reg_idx == `TCA_IDX_CI_DETECT);

	// Request phases: accepted in idle, completed in ack
	wire bus_req = i_avs_read ^ i_avs_write;
	wire in_ack = bus_state_q == tca_pkg::bus_ack;
	wire rd_take = in_ack && i_avs_read;
	wire wr_take = in_ack && i_avs_write && i_avs_byteenable[0];
	wire [7:0] wbyte = i_avs_writedata[7:0];

	// Bus state machine
	always_comb
	begin
		bus_state_d = bus_state_q;
		case (bus_state_q)
			tca_pkg::bus_idle: if (bus_req) bus_state_d = tca_pkg::bus_ack;
			tca_pkg::bus_ack: bus_state_d = tca_pkg::bus_idle;
			default: bus_state_d = tca_pkg::bus_idle;
		endcase
	end

	// Live alarm bits, gated by detection enables; RAI-CI also by framing mode
	wire ais_live_d = det_bus.ais_det & det_en_q[`TCA_BIT_DET_AIS];
	wire rai_live_d = det_bus.rai_det & det_en_q[`TCA_BIT_DET_RAI] & i_esf_mode;

	// Both edges of each live bit count as a change
	wire ais_chg_ev = ais_live_d ^ ais_live_q;
	wire rai_chg_ev = rai_live_d ^ rai_live_q;

	// Oversize event fires once, on the byte that passes the limit
	wire lapd3_cnt_sat = lapd3_cnt_q == 9'h1ff;
	wire lapd3_over_ev = i_lapd3_rx_byte && (lapd3_cnt_q == `TCA_LAPD_MAX_BYTES);

	always_comb
	begin
		lapd3_cnt_d = lapd3_cnt_q;
		if (i_lapd3_rx_byte && !lapd3_cnt_sat) lapd3_cnt_d = lapd3_cnt_q + 9'h001;
		if (i_lapd3_rx_eom) lapd3_cnt_d = 9'h000;
	end

	// Read clears only what the captured read data showed, so a bit set
	// between capture and completion is kept for the next read
	wire [1:0] ci_rd_clr = (rd_take && hit_ci_st) ? rdata_q[1:0] : 2'h0;
	wire [1:0] ci_wr_clr = (wr_take && hit_ci_st) ? wbyte[1:0] : 2'h0;
	wire [1:0] ci_clr = ci_rd_clr | ci_wr_clr;
	wire lapd3_rd_clr = rd_take && hit_lapd3_st && rdata_q[`TCA_BIT_LAPD3];
	wire lapd3_wr_clr = wr_take && hit_lapd3_st && wbyte[`TCA_BIT_LAPD3];

	// Sticky flags: a new event wins over a clear in the same cycle
	always_comb
	begin
		ais_flag_d = (ais_flag_q & ~ci_clr[`TCA_BIT_AIS_CHG]) | ais_chg_ev;
		rai_flag_d = (rai_flag_q & ~ci_clr[`TCA_BIT_RAI_CHG]) | rai_chg_ev;
		lapd3_flag_d = (lapd3_flag_q & ~(lapd3_rd_clr | lapd3_wr_clr)) | lapd3_over_ev;
	end

	// Enable and detection registers; only defined bits are stored
	always_comb
	begin
		lapd3_en_d = lapd3_en_q;
		ci_en_d = ci_en_q;
		det_en_d = det_en_q;
		if (wr_take && hit_lapd3_en) lapd3_en_d = wbyte[`TCA_BIT_LAPD3];
		if (wr_take && hit_ci_en) ci_en_d = wbyte[1:0];
		if (wr_take && hit_det) det_en_d = wbyte[1:0];
	end

	// Read data views; reserved bits are constant zero
	wire [7:0] rd_ci_st = {2'h0, ais_live_q, rai_live_q, 2'h0, ais_flag_q, rai_flag_q};
	wire [7:0] rd_ci_en = {6'h00, ci_en_q};
	wire [7:0] rd_det = {6'h00, det_en_q};
	wire [7:0] rd_lapd3_st = {7'h00, lapd3_flag_q};
	wire [7:0] rd_lapd3_en = {7'h00, lapd3_en_q};

	// Unmapped addresses read zero and complete normally
	wire [7:0] rd_mux = hit_ci_st ? rd_ci_st :
		hit_ci_en ? rd_ci_en :
		hit_det ? rd_det :
		hit_lapd3_st ? rd_lapd3_st :
		hit_lapd3_en ? rd_lapd3_en : 8'h00;

	// Interrupt combines every enabled sticky flag
	wire irq_d = (ais_flag_q & ci_en_q[`TCA_BIT_AIS_CHG]) |
		(rai_flag_q & ci_en_q[`TCA_BIT_RAI_CHG]) |
		(lapd3_flag_q & lapd3_en_q);

	// Millisecond tick for the RAI-CI timing
	wire div_wrap = div_q == 14'(MS_CYCLES - 1);

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			div_q <= 14'h0000;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q <= div_wrap ? 14'h0000 : div_q + 14'h0001;
			tick_q <= div_wrap;
		end
	end

	// Bus slave; one wait-free cycle per request
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			bus_state_q <= tca_pkg::bus_idle;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			bus_state_q <= bus_state_d;
			wait_q <= bus_state_d != tca_pkg::bus_ack;
			if (!in_ack && bus_req && i_avs_read) rdata_q <= {24'h000000, rd_mux};
		end
	end

	// Reset image of a register, split per field below
	wire [7:0] rst_val = `TCA_RST_REG;

	// Control registers
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			lapd3_en_q <= rst_val[`TCA_BIT_LAPD3];
			ci_en_q <= rst_val[1:0];
			det_en_q <= rst_val[1:0];
		end
		else
		begin
			lapd3_en_q <= lapd3_en_d;
			ci_en_q <= ci_en_d;
			det_en_q <= det_en_d;
		end
	end

	// Status state, counter and interrupt
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			ais_live_q <= 1'b0;
			rai_live_q <= 1'b0;
			ais_flag_q <= 1'b0;
			rai_flag_q <= 1'b0;
			lapd3_flag_q <= 1'b0;
			lapd3_cnt_q <= 9'h000;
			irq_q <= 1'b0;
		end
		else
		begin
			ais_live_q <= ais_live_d;
			rai_live_q <= rai_live_d;
			ais_flag_q <= ais_flag_d;
			rai_flag_q <= rai_flag_d;
			lapd3_flag_q <= lapd3_flag_d;
			lapd3_cnt_q <= lapd3_cnt_d;
			irq_q <= irq_d;
		end
	end

	assign o_avs_readdata = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_irq = irq_q;
endmodule : tca_ci_alarm_status_irq

// *** testbench/tca_line_model.sv ***
`timescale 1ns/1ns
`include "tca_map.svh"
module tca_line_model #(
	parameter int MS_CYCLES = 4 // Clock cycles per 1 ms tick, as in the design
) (
	input wire logic i_clock, // Framer clock
	input wire logic i_rst_b, // Synchronous reset, active low
	input wire logic i_sig_on, // Embed the recurring signature
	output logic o_rx_bit, // Received line bit
	output logic o_rx_bit_valid, // One bit every cycle
	output logic o_dl_bit, // Received data link bit
	output logic o_dl_bit_valid // One data link bit every cycle
);
	logic [8:0] pos_q;
	logic [15:0] rai_pos_q;
	wire logic [15:0] sig_w = `TCA_AIS_SIG;
	wire logic [15:0] rai_msg_w = `TCA_RAI_MSG;
	wire logic [15:0] rai_sig_w = `TCA_RAI_SIG;
	wire logic rai_in_msg_w = rai_pos_q < 16'(`TCA_RAI_MSG_MS * MS_CYCLES);
	wire logic rai_wrap_w = rai_pos_q == 16'(`TCA_RAI_PERIOD_MS * MS_CYCLES - 1);

	// All ones, signature sent low bit first; without it the stream is plain ones
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			pos_q <= 9'h000;
			o_rx_bit <= 1'b1;
			o_rx_bit_valid <= 1'b0;
		end
		else
		begin
			o_rx_bit_valid <= 1'b1;
			o_rx_bit <= (i_sig_on && pos_q < 9'h010) ? sig_w[pos_q[3:0]] : 1'b1;
			pos_q <= (pos_q == `TCA_AIS_PERIOD_BITS - 9'h001) ? 9'h000 : pos_q + 9'h001;
		end
	end

	// Data link: RAI message run, then signature run, each word low bit first
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b)
		begin
			rai_pos_q <= 16'h0000;
			o_dl_bit <= 1'b1;
			o_dl_bit_valid <= 1'b0;
		end
		else
		begin
			o_dl_bit_valid <= 1'b1;
			o_dl_bit <= rai_in_msg_w ? rai_msg_w[rai_pos_q[3:0]] : rai_sig_w[rai_pos_q[3:0]];
			rai_pos_q <= rai_wrap_w ? 16'h0000 : rai_pos_q + 16'h0001;
		end
	end
endmodule : tca_line_model

// *** testbench/tca_ci_alarm_status_irq_sva.sv ***
`timescale 1ns/1ns
`include "tca_map.svh"
module tca_ci_alarm_status_irq_sva #(
	parameter int MS_CYCLES = 4 // Same tick length as the design
) (
	input wire logic i_clock, // Framer clock
	input wire logic i_rst_b, // Synchronous reset, active low
	input wire logic [13:0] i_avs_address, // Byte address
	input wire logic i_avs_read, // Read request
	input wire logic i_avs_write, // Write request
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [3:0] i_avs_byteenable, // Byte enables
	input wire logic [31:0] o_avs_readdata, // Read data
	input wire logic o_avs_waitrequest, // Wait
	input wire logic i_rx_bit, // Line bit
	input wire logic i_rx_bit_valid, // Line strobe
	input wire logic i_dl_bit, // Data link bit
	input wire logic i_dl_bit_valid, // Data link strobe
	input wire logic i_esf_mode, // ESF framing
	input wire logic i_lapd3_rx_byte, // Message byte pulse
	input wire logic i_lapd3_rx_eom, // End of message
	input wire logic o_irq // Interrupt
);
	logic [9:0] cnt_q;
	logic en_q;
	wire logic wr_done_w = i_avs_write && !o_avs_waitrequest;
	wire logic en_hit_w = wr_done_w && i_avs_byteenable[0]
		&& i_avs_address == {`TCA_IDX_LAPD3_ENABLE, 2'b00};
	wire logic ci_rd_w = i_avs_read && !o_avs_waitrequest
		&& i_avs_address == {`TCA_IDX_CI_STATUS, 2'b00};

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	// Shadow of the byte count and the oversize enable, seen from the pins only
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_b || i_lapd3_rx_eom)
			cnt_q <= 10'h000;
		else if (i_lapd3_rx_byte && cnt_q != 10'h3ff)
			cnt_q <= cnt_q + 10'h001;
		if (!i_rst_b)
			en_q <= 1'b0;
		else if (en_hit_w)
			en_q <= i_avs_writedata[0];
	end

	reset_quiet_a: assert property (disable iff (1'b0) !i_rst_b |=> o_avs_waitrequest && !o_irq
		&& o_avs_readdata == 32'h0) else $error("outputs not quiet in reset");
	wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	bus_answer_a: assert property ($rose(i_avs_read ^ i_avs_write) |=> !o_avs_waitrequest)
		else $error("request not answered after one cycle");
	wait_cause_a: assert property (!o_avs_waitrequest |-> i_avs_read || i_avs_write)
		else $error("waitrequest low without request");
	rdata_hold_a: assert property ($rose(o_avs_waitrequest) |-> $stable(o_avs_readdata))
		else $error("read data moved over the completing edge");
	upper_zero_a: assert property (o_avs_readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	reserved_zero_a: assert property (ci_rd_w |-> o_avs_readdata[7:6] == 2'h0
		&& o_avs_readdata[3:2] == 2'h0) else $error("reserved status bits set");
	oversize_irq_a: assert property (i_lapd3_rx_byte && cnt_q == 10'h114 && en_q |-> ##2 o_irq)
		else $error("oversize message raised no interrupt");
	irq_fall_a: assert property ($fell(o_irq) |-> !$past(o_avs_waitrequest, 2))
		else $error("interrupt dropped without a register access");

	cover_oversize: cover property (i_lapd3_rx_byte && cnt_q == 10'h114 && en_q);
	cover_irq: cover property ($rose(o_irq));
	cover_ci_read: cover property (ci_rd_w && o_avs_readdata[5]);
endmodule : tca_ci_alarm_status_irq_sva

bind tca_ci_alarm_status_irq tca_ci_alarm_status_irq_sva #(.MS_CYCLES(MS_CYCLES))
	i_tca_ci_alarm_status_irq_sva (.i_clock(i_clock), .i_rst_b(i_rst_b),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_rx_bit(i_rx_bit), .i_rx_bit_valid(i_rx_bit_valid), .i_dl_bit(i_dl_bit),
	.i_dl_bit_valid(i_dl_bit_valid), .i_esf_mode(i_esf_mode),
	.i_lapd3_rx_byte(i_lapd3_rx_byte), .i_lapd3_rx_eom(i_lapd3_rx_eom), .o_irq(o_irq));

// *** testbench/tca_ci_alarm_status_irq_tb_top.sv ***
`timescale 1ns/1ns
`include "tca_map.svh"
`define CHK(act, exp) \
	begin \
		n_checks++; \
		if ((act) !== (exp)) \
		begin \
			err_count++; \
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, act, exp); \
		end \
	end
module tca_ci_alarm_status_irq_tb_top;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [13:0] avs_address = 14'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic rx_bit;
	logic rx_bit_valid;
	logic lapd_byte = 1'b0;
	logic lapd_eom = 1'b0;
	logic sig_on = 1'b1;
	logic esf = 1'b0;
	logic dl_bit;
	logic dl_bit_valid;
	logic irq;
	logic [7:0] rd;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;

	// 100 ns clock
	initial
	begin
		forever #50 i_clock = ~i_clock;
	end

	tca_ci_alarm_status_irq #(.MS_CYCLES(4)) i_tca_ci_alarm_status_irq (.i_clock(i_clock),
		.i_rst_b(i_rst_b), .i_avs_address(avs_address), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'h1),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_rx_bit(rx_bit), .i_rx_bit_valid(rx_bit_valid), .i_dl_bit(dl_bit),
		.i_dl_bit_valid(dl_bit_valid), .i_esf_mode(esf), .i_lapd3_rx_byte(lapd_byte),
		.i_lapd3_rx_eom(lapd_eom), .o_irq(irq));

	tca_line_model #(.MS_CYCLES(4)) i_tca_line_model (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_sig_on(sig_on), .o_rx_bit(rx_bit), .o_rx_bit_valid(rx_bit_valid),
		.o_dl_bit(dl_bit), .o_dl_bit_valid(dl_bit_valid));

	task finish_test;
		$display("Comparisons %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// Hang guard, well above the expected run of about 20000 cycles
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			finish_test();
		end
	end

	// One bus transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
		@(posedge i_clock);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge i_clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		`CHK(rd, exp);
	endtask : rd_chk

	// A whole message of n byte pulses, then its end
	task automatic send_msg(input int n);
		repeat (n)
		begin
			@(posedge i_clock);
			lapd_byte <= 1'b1;
			@(posedge i_clock);
			lapd_byte <= 1'b0;
		end
		@(posedge i_clock);
		lapd_eom <= 1'b1;
		@(posedge i_clock);
		lapd_eom <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask : send_msg

	// Main sequence
	initial
	begin
		repeat (6) @(posedge i_clock);
		i_rst_b <= 1'b1;
		rd_chk(`TCA_IDX_LAPD3_STATUS, `TCA_RST_REG);
		rd_chk(`TCA_IDX_LAPD3_ENABLE, `TCA_RST_REG);
		rd_chk(`TCA_IDX_CI_ENABLE, `TCA_RST_REG);
		rd_chk(12'h123, 8'h00);
		// Signature present but detection off: nothing reported
		repeat (2000) @(posedge i_clock);
		bus(1'b1, `TCA_IDX_CI_STATUS, 8'hff);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h00);
		bus(1'b1, `TCA_IDX_LAPD3_ENABLE, 8'hff);
		bus(1'b1, `TCA_IDX_CI_ENABLE, 8'hff);
		rd_chk(`TCA_IDX_LAPD3_ENABLE, 8'h01);
		rd_chk(`TCA_IDX_CI_ENABLE, 8'h03);
		// Oversize boundary: 276 bytes is legal, 277 is not
		send_msg(276);
		`CHK(irq, 1'b0);
		rd_chk(`TCA_IDX_LAPD3_STATUS, 8'h00);
		send_msg(277);
		`CHK(irq, 1'b1);
		rd_chk(`TCA_IDX_LAPD3_STATUS, 8'h01);
		repeat (3) @(posedge i_clock);
		`CHK(irq, 1'b0);
		rd_chk(`TCA_IDX_LAPD3_STATUS, 8'h00);
		// AIS-CI onset with detection on
		bus(1'b1, `TCA_IDX_CI_DETECT, 8'h02);
		repeat (7 * 386) @(posedge i_clock);
		`CHK(irq, 1'b1);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h22);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h20);
		`CHK(irq, 1'b0);
		// Clearing with the change interrupt masked
		bus(1'b1, `TCA_IDX_CI_ENABLE, 8'h00);
		@(posedge i_clock);
		sig_on <= 1'b0;
		repeat (3 * 386) @(posedge i_clock);
		`CHK(irq, 1'b0);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h02);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h00);
		// RAI-CI in ESF: onset, detection enable toggled, then leaving ESF
		bus(1'b1, `TCA_IDX_CI_DETECT, 8'h03);
		bus(1'b1, `TCA_IDX_CI_ENABLE, 8'h01);
		@(posedge i_clock);
		esf <= 1'b1;
		// Three 1080 ms periods of 4320 cycles each at a 4-cycle tick
		repeat (3 * 4320) @(posedge i_clock);
		`CHK(irq, 1'b1);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h11);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h10);
		bus(1'b1, `TCA_IDX_CI_DETECT, 8'h02);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h01);
		bus(1'b1, `TCA_IDX_CI_DETECT, 8'h03);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h11);
		@(posedge i_clock);
		esf <= 1'b0;
		repeat (3) @(posedge i_clock);
		`CHK(irq, 1'b1);
		rd_chk(`TCA_IDX_CI_STATUS, 8'h01);
		finish_test();
	end
endmodule : tca_ci_alarm_status_irq_tb_top
